// ### verilog/adsc_scan_config.sv
// scan configuration, scan sequencer and data buffer of the converter board
// assumes host strobes and converter results synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none

module adsc_scan_config
  import adsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [DATA_W-1:0] bus_wdata,
  output logic [DATA_W-1:0] bus_rdata_q,
  input wire logic irq_enable,
  output logic irq_q,
  input wire logic ext_trig,
  input wire logic timer_trig,
  output logic conv_req_q,
  output logic [CHAN_W-1:0] conv_chan_q,
  output logic conv_gain_x10_q,
  input wire logic conv_valid,
  output logic conv_ready_q,
  input wire logic [DATA_W-1:0] conv_data
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  localparam int unsigned BUF_WORDS_C = 1 << BUF_AW;

  logic [DATA_W-1:0] ccr_q;
  logic [1:0] tmode_q;
  logic mid_flag_q;
  logic [CHANNELS-1:0] gain_q;
  logic [DATA_W-1:0] dcount_q;
  logic [DATA_W-1:0] dtarget_q;
  logic dhit_q;
  logic data_rdy_q;
  adsc_state_t state_q;
  logic [BUF_AW-1:0] idx_q;
  logic [DATA_W-1:0] buf_mem [BUF_WORDS_C];

  logic clr;
  logic wr_ccr;
  logic wr_csr;
  logic wr_gain;
  logic wr_dcount;
  logic sw_trig;
  logic hit_buf;
  logic hit_mem;
  logic [ADDR_W-1:0] buf_off;
  logic [BUF_AW-1:0] host_idx;
  logic host_buf_wr;
  logic trig;
  logic [4:0] bufc;
  logic [1:0] gmode;
  logic [1:0] smode;
  logic [CHAN_W-1:0] grp;
  logic random_mode;
  logic [4:0] big_t;
  logic [2:0] sz;
  logic [2:0] bk;
  logic [CHAN_W-1:0] blk_mask;
  logic [BUF_AW:0] words;
  logic [BUF_AW-1:0] last_idx;
  logic [BUF_AW-1:0] mid_idx;
  logic [CHAN_W-1:0] chan_d;
  logic gain_d;
  logic res_valid;
  logic res_ready;
  logic [DATA_W-1:0] res_data;
  logic res_take;
  logic [BUF_AW-1:0] wr_loc;
  logic scan_end;
  logic rdy_set;
  logic [DATA_W-1:0] dcount_inc;
  logic [DATA_W-1:0] rdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // host address decode

  // software reset acts as a synchronous clear
  assign clr = !rst_n || (bus_wr && bus_addr == OFS_SWRESET); // RQ17
  assign wr_ccr = bus_wr && bus_addr == OFS_CCR;
  assign wr_csr = bus_wr && bus_addr == OFS_CSR;
  assign wr_gain = bus_wr && bus_addr == OFS_GAIN;
  assign wr_dcount = bus_wr && bus_addr == OFS_DCOUNT;
  assign sw_trig = bus_wr && bus_addr == OFS_SWTRIG;

  // whole buffer and scratch range
  assign hit_buf = bus_addr >= OFS_BUF_LO && bus_addr <= OFS_BUF_HI; // RQ9
  assign hit_mem = bus_addr >= OFS_BUF_LO && bus_addr <= OFS_RAM_HI;
  assign buf_off = bus_addr - OFS_BUF_LO;
  assign host_idx = buf_off[BUF_AW:1];
  assign host_buf_wr = bus_wr && hit_buf;

  ////////////////////////////////////////////////////////////////////////////
  // configuration fields

  assign bufc = ccr_q[CCR_BUFC_HI:CCR_BUFC_LO]; // RQ1
  assign gmode = ccr_q[CCR_GMODE_HI:CCR_GMODE_LO]; // RQ1
  assign smode = ccr_q[CCR_SMODE_HI:CCR_SMODE_LO]; // RQ1
  assign grp = ccr_q[CCR_GRP_HI:CCR_GRP_LO]; // RQ1
  assign random_mode = smode[1]; // RQ6
  assign big_t = bufc - BUFC_BIG;

  // buffer size index and block size index from the buffer code
  always_comb begin
    sz = '0;
    bk = '0;
    if (bufc < BUFC_32) begin
      bk = bufc[2:0];
    end else if (bufc < BUFC_64) begin
      sz = 3'(SZ_32);
      bk = 3'(bufc - BUFC_32);
    end else if (bufc < BUFC_BIG) begin
      sz = 3'(SZ_64);
      bk = 3'(bufc - BUFC_64);
    end else begin
      for (int k = 0; k < BIG_GROUPS; k++) begin
        if (big_t >= 5'(k * BUFC_GROUP)) begin
          sz = 3'(SZ_BIG + k);
          bk = 3'(big_t - 5'(k * BUFC_GROUP));
        end
      end
    end
  end

  // low channel bits that walk inside one block
  always_comb begin
    case (bk)
      3'h0: blk_mask = 6'h00;
      3'h1: blk_mask = 6'h07;
      3'h2: blk_mask = 6'h0F;
      3'h3: blk_mask = 6'h1F;
      default: blk_mask = 6'h3F;
    endcase
  end

  // programmed buffer length, last and middle word
  assign words = (BUF_AW + 1)'(MIN_BUF_WORDS) << sz; // RQ10
  assign last_idx = BUF_AW'(words - 1'b1); // RQ10
  assign mid_idx = last_idx >> 1;

  // channel for the word about to be converted
  always_comb begin
    if (random_mode || blk_mask == '0) begin
      chan_d = grp; // RQ7 RQ8
    end else begin
      chan_d = ({grp[2:0], 3'h0} & ~blk_mask) | (idx_q[CHAN_W-1:0] & blk_mask); // RQ12 RQ14
    end
  end

  // gain of that channel
  always_comb begin
    if (gmode[1]) begin
      gain_d = gain_q[chan_d]; // RQ3
    end else begin
      gain_d = gmode[0]; // RQ3
    end
  end

  // trigger source selection, reserved code never fires
  always_comb begin
    case (tmode_q)
      TMODE_SW: trig = sw_trig; // RQ16
      TMODE_EXT: trig = ext_trig; // RQ16
      TMODE_TIMER: trig = timer_trig; // RQ16
      default: trig = 1'b0; // RQ16
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // result fifo between converter and buffer

  // drained only while a result is awaited and the host is not writing the buffer
  assign res_ready = (state_q == ST_WAIT) && !host_buf_wr;
  assign res_take = res_valid && res_ready;
  assign wr_loc = random_mode ? '0 : idx_q; // RQ6
  assign scan_end = !random_mode && idx_q == last_idx;

  adsc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(conv_valid),
    .in_ready_q(conv_ready_q),
    .in_data(conv_data),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers written by the host

  // scan configuration register
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ccr_q <= CCR_RESET; // RQ17
    end else if (wr_ccr) begin
      ccr_q <= bus_wdata; // RQ1
    end
  end

  // trigger mode and data ready position
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      tmode_q <= TMODE_RESET; // RQ16
      mid_flag_q <= 1'b0;
    end else if (wr_csr) begin
      tmode_q <= bus_wdata[CSR_TMODE_HI:CSR_TMODE_LO]; // RQ16
      mid_flag_q <= bus_wdata[CSR_MIDFLAG];
    end
  end

  // per-channel auto gain table
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      gain_q <= '0;
    end else if (wr_gain) begin
      gain_q[bus_wdata[CHAN_W-1:0]] <= bus_wdata[GAIN_X10]; // RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer

  // armed waits for a trigger, conv asks for one result, wait stores it
  always_ff @(posedge ref_clk) begin
    if (clr || wr_ccr) begin
      state_q <= ST_ARMED;
      idx_q <= '0;
    end else begin
      case (state_q)
        ST_ARMED: begin
          if (trig) begin
            state_q <= ST_CONV;
            idx_q <= '0;
          end
        end
        ST_CONV: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (res_take) begin
            if (random_mode) begin
              state_q <= ST_ARMED; // RQ6
            end else if (scan_end) begin
              idx_q <= '0;
              if (smode == SMODE_SINGLE) begin
                state_q <= ST_ARMED; // RQ5
              end else begin
                state_q <= ST_CONV; // RQ4
              end
            end else begin
              idx_q <= idx_q + 1'b1; // RQ10
              state_q <= ST_CONV;
            end
          end
        end
        default: begin
          state_q <= ST_ARMED;
        end
      endcase
    end
  end

  // conversion request with channel and gain
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      conv_req_q <= 1'b0;
      conv_chan_q <= '0;
      conv_gain_x10_q <= 1'b0;
    end else begin
      conv_req_q <= (state_q == ST_CONV) && !wr_ccr;
      if (state_q == ST_CONV) begin
        conv_chan_q <= chan_d; // RQ7 RQ12
        conv_gain_x10_q <= gain_d; // RQ3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data buffer

  // host writes take priority; scan stores stall in the fifo meanwhile
  always_ff @(posedge ref_clk) begin
    if (host_buf_wr) begin
      buf_mem[host_idx] <= bus_wdata; // RQ9
    end else if (res_take) begin
      buf_mem[wr_loc] <= res_data; // RQ6 RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data ready, data counter and interrupt request

  assign rdy_set = res_take && (random_mode || scan_end || (mid_flag_q && idx_q == mid_idx));

  // set wins over a clearing read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      data_rdy_q <= 1'b0;
    end else if (rdy_set) begin
      data_rdy_q <= 1'b1; // RQ15
    end else if (bus_rd && hit_mem) begin
      data_rdy_q <= 1'b0; // RQ15
    end
  end

  assign dcount_inc = dcount_q + 1'b1;

  // conversion counter against the programmed count
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      dcount_q <= '0;
      dtarget_q <= '0;
      dhit_q <= 1'b0;
    end else begin
      if (wr_dcount) begin
        dtarget_q <= bus_wdata;
        dcount_q <= '0;
      end else if (res_take) begin
        dcount_q <= (dcount_inc == dtarget_q) ? '0 : dcount_inc;
      end
      if (res_take && !wr_dcount && dtarget_q != '0 && dcount_inc == dtarget_q) begin
        dhit_q <= 1'b1; // RQ2
      end else if (wr_dcount) begin
        dhit_q <= 1'b0;
      end
    end
  end

  // interrupt request from the selected source
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_enable && (ccr_q[CCR_ISRC] ? dhit_q : data_rdy_q); // RQ2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read path

  // read data for the addressed location
  always_comb begin
    rdata_d = '0;
    if (bus_addr == OFS_CSR) begin
      rdata_d[CSR_TMODE_HI:CSR_TMODE_LO] = tmode_q;
      rdata_d[CSR_MIDFLAG] = mid_flag_q;
      rdata_d[CSR_RDY] = data_rdy_q;
      rdata_d[CSR_ARMED] = (state_q == ST_ARMED);
      rdata_d[CSR_TRIGED] = (state_q != ST_ARMED);
    end else if (bus_addr == OFS_CCR) begin
      rdata_d = ccr_q;
    end else if (bus_addr == OFS_DCOUNT) begin
      rdata_d = dcount_q;
    end else if (hit_buf) begin
      rdata_d = buf_mem[host_idx]; // RQ9
    end
  end

  // registered read answer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_rdata_q <= '0;
    end else if (bus_rd) begin
      bus_rdata_q <= rdata_d;
    end
  end

endmodule // adsc_scan_config

`default_nettype wire

// ### verilog/adsc_pkg.sv
// constants, field layout and state type of the scan configuration block
// assumes a 16-bit host port with byte offsets and one board clock
//
// Overview of operation
// RQ1 - sixteen-bit configuration register with five fields
// RQ2 - interrupt source: data counter or data ready
// RQ3 - gain: fixed one, fixed ten, per-channel
// RQ4 - auto scan re-arms and re-triggers at end
// RQ5 - single scan stops at end, awaits trigger
// RQ6 - random access converts one channel into location zero
// RQ7 - group field selects group or single channel
// RQ8 - single-channel codes fill whole buffer with one channel
// RQ9 - host reaches all 1024 buffer words always
// RQ10 - scan updates only programmed buffer size words
// RQ11 - host picks block size legal for buffer size
// RQ12 - channel groups aligned to block size
// RQ13 - host picks groups fitted on board variant
// RQ14 - don't-care configuration bits never change behaviour
// RQ15 - data ready sets on scan done, buffer read clears
// RQ16 - trigger mode: software, external, timer, reserved
// RQ17 - resets clear configuration register to zero
package adsc_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BUF_AW = 10;
  localparam int unsigned CHAN_W = 6;
  localparam int unsigned CHANNELS = 64;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned MIN_BUF_WORDS = 16;

  // register offsets
  localparam logic [11:0] OFS_CSR = 12'h002;
  localparam logic [11:0] OFS_CCR = 12'h004;
  localparam logic [11:0] OFS_SWRESET = 12'h00C;
  localparam logic [11:0] OFS_SWTRIG = 12'h00E;
  localparam logic [11:0] OFS_GAIN = 12'h010;
  localparam logic [11:0] OFS_DCOUNT = 12'h024;
  localparam logic [11:0] OFS_BUF_LO = 12'h080;
  localparam logic [11:0] OFS_BUF_HI = 12'h87E;
  localparam logic [11:0] OFS_RAM_HI = 12'hFFE;

  // scan configuration fields
  localparam int unsigned CCR_BUFC_HI = 15;
  localparam int unsigned CCR_BUFC_LO = 11;
  localparam int unsigned CCR_ISRC = 10;
  localparam int unsigned CCR_GMODE_HI = 9;
  localparam int unsigned CCR_GMODE_LO = 8;
  localparam int unsigned CCR_SMODE_HI = 7;
  localparam int unsigned CCR_SMODE_LO = 6;
  localparam int unsigned CCR_GRP_HI = 5;
  localparam int unsigned CCR_GRP_LO = 0;
  localparam logic [15:0] CCR_RESET = 16'h0000;

  // control and status fields
  localparam int unsigned CSR_TMODE_HI = 13;
  localparam int unsigned CSR_TMODE_LO = 12;
  localparam int unsigned CSR_MIDFLAG = 10;
  localparam int unsigned CSR_RDY = 6;
  localparam int unsigned CSR_ARMED = 5;
  localparam int unsigned CSR_TRIGED = 4;

  // gain table write word
  localparam int unsigned GAIN_X10 = 6;

  // mode codes
  localparam logic [1:0] SMODE_SINGLE = 2'h1;
  localparam logic [1:0] TMODE_SW = 2'h0;
  localparam logic [1:0] TMODE_EXT = 2'h1;
  localparam logic [1:0] TMODE_TIMER = 2'h2;
  localparam logic [1:0] TMODE_RESET = 2'h0;

  // buffer configuration code groups
  localparam logic [4:0] BUFC_32 = 5'h03;
  localparam logic [4:0] BUFC_64 = 5'h07;
  localparam logic [4:0] BUFC_BIG = 5'h0C;
  localparam int unsigned BUFC_GROUP = 5;
  localparam int unsigned BIG_GROUPS = 4;
  localparam int unsigned SZ_32 = 1;
  localparam int unsigned SZ_64 = 2;
  localparam int unsigned SZ_BIG = 3;

  typedef enum logic [1:0] {
    ST_ARMED,
    ST_CONV,
    ST_WAIT
  } adsc_state_t;

endpackage

// ### verilog/adsc_fifo.sv
// small synchronous fifo for converter results
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module adsc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready_q,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = in_valid && in_ready_q;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  // occupancy next value
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != CW'(DEPTH));
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule // adsc_fifo

`default_nettype wire

// ### dv/adsc_scan_config_sva.sv
// checker for the scan configuration block
// assumes a bind onto adsc_scan_config, one clock domain
`timescale 1ns/1ns
`default_nettype none

module adsc_scan_chk
  import adsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic [DATA_W-1:0] bus_rdata_q,
  input wire logic irq_enable,
  input wire logic irq_q,
  input wire logic conv_req_q,
  input wire logic [CHAN_W-1:0] conv_chan_q,
  input wire logic conv_gain_x10_q
);
  logic [15:0] cfg_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // shadow of the configuration word, cleared by either reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (bus_wr && bus_addr == OFS_SWRESET)) begin
      cfg_q <= 16'h0000;
    end else if (bus_wr && bus_addr == OFS_CCR) begin
      cfg_q <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_cfg_readback: assert property (
    bus_rd && !bus_wr && bus_addr == OFS_CCR |=> bus_rdata_q == cfg_q)
    else $error("config read differs from last write");
  a_rdata_hold: assert property (
    !bus_rd |=> $stable(bus_rdata_q))
    else $error("read data changed without a read");
  a_req_spacing: assert property (
    conv_req_q |=> !conv_req_q [*2])
    else $error("conversion request too long or too close");
  a_chan_hold: assert property (
    !conv_req_q && !$past(bus_wr) |-> $stable(conv_chan_q) && $stable(conv_gain_x10_q))
    else $error("channel or gain moved between requests");
  a_gain_fixed: assert property (
    conv_req_q && !$past(bus_wr) && !cfg_q[9] |-> conv_gain_x10_q == cfg_q[8])
    else $error("fixed gain not applied");
  a_random_chan: assert property (
    conv_req_q && !$past(bus_wr) && cfg_q[7] |-> conv_chan_q == cfg_q[5:0])
    else $error("random access channel wrong");
  a_single_chan: assert property (
    conv_req_q && !$past(bus_wr) && !cfg_q[7] && cfg_q[15:11] inside {5'h00, 5'h03, 5'h07, 5'h0C, 5'h11, 5'h16}
    |-> conv_chan_q == cfg_q[5:0])
    else $error("single channel fill used wrong channel");
  a_block_align: assert property (
    conv_req_q && !$past(bus_wr) && !cfg_q[7] && cfg_q[15:11] == 5'h01 |-> conv_chan_q[5:3] == cfg_q[2:0])
    else $error("block channel outside its group");
  a_irq_enabled: assert property (
    $rose(irq_q) |-> $past(irq_enable))
    else $error("interrupt raised while disabled");
endmodule // adsc_scan_chk

`default_nettype wire

// ### dv/adsc_conv_model.sv
// converter model on the far side of the conversion port
// assumes result word {gain, 9'h000, channel}, alternating fast and slow answers
`timescale 1ns/1ns
`default_nettype none

module adsc_conv_model
  import adsc_pkg::*;
(
  input wire logic clk,
  input wire logic req,
  input wire logic [CHAN_W-1:0] chan,
  input wire logic gain,
  input wire logic ready,
  input wire logic flood,
  output logic valid,
  output logic [DATA_W-1:0] data
);
  int slow;

  // answer each request, hold valid until taken; flood sends unasked results
  initial begin
    valid = 1'b0;
    data = 16'hFFFF;
    slow = 0;
    forever begin
      @(posedge clk);
      if (req && !flood) begin
        repeat (slow) @(posedge clk);
        slow = 3 - slow;
        valid <= 1'b1;
        data <= {gain, 9'h000, chan};
        do @(posedge clk); while (!ready);
        valid <= 1'b0;
        data <= ~{gain, 9'h000, chan}; // released lines show no stale value
      end else begin
        valid <= flood;
      end
    end
  end
endmodule // adsc_conv_model

`default_nettype wire

// ### dv/tb_adsc_scan_config.sv
// self-checking bench for the scan configuration block
// assumes the converter model on the conversion port
`timescale 1ns/1ns
`default_nettype none

module tb_adsc_scan_config;
  import adsc_pkg::*;
  logic ref_clk, rst_n, bus_wr, bus_rd, irq_enable, ext_trig, timer_trig, flood;
  logic irq_q, conv_req_q, conv_gain_x10_q, conv_valid, conv_ready_q;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata_q, conv_data, d;
  logic [CHAN_W-1:0] conv_chan_q;
  int miscompares, cmp_count;

  // 10 MHz board clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  adsc_scan_config i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .irq_enable(irq_enable),
    .irq_q(irq_q), .ext_trig(ext_trig), .timer_trig(timer_trig), .conv_req_q(conv_req_q),
    .conv_chan_q(conv_chan_q), .conv_gain_x10_q(conv_gain_x10_q), .conv_valid(conv_valid),
    .conv_ready_q(conv_ready_q), .conv_data(conv_data));

  adsc_conv_model i_conv (.clk(ref_clk), .req(conv_req_q), .chan(conv_chan_q), .gain(conv_gain_x10_q),
    .ready(conv_ready_q), .flood(flood), .valid(conv_valid), .data(conv_data));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [15:0] e, input bit cmp = 1'b1);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_q;
    if (cmp) chk(nm, d, e);
  endtask

  // poll status until data ready, bounded
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      rdc("status", OFS_CSR, 16'h0000, 1'b0);
      i++;
    end while (!d[CSR_RDY] && i < 300);
    chk("data ready", {15'h0, d[CSR_RDY]}, 16'h0001);
  endtask

  task automatic scan_chk(input string nm, input int n, input logic [15:0] base, input int m);
    for (int k = 0; k < n; k++) begin
      rdc(nm, OFS_BUF_LO + 12'(2 * k), base + 16'(k % m));
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    {rst_n, bus_wr, bus_rd, ext_trig, timer_trig, flood} = 6'h00;
    bus_addr = 12'h000;
    bus_wdata = 16'h0000;
    irq_enable = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc("config", OFS_CCR, 16'h0000);
    rdc("status", OFS_CSR, 16'h0020);
    wr(12'h0900, 16'h5555);
    rdc("scratch", 12'h0900, 16'h0000);
    rdc("unmapped", 12'h0006, 16'h0000);
    wr(OFS_CCR, 16'hA5C3);
    rdc("config", OFS_CCR, 16'hA5C3);
    // single scan of one channel, fixed gain ten
    wr(OFS_BUF_LO + 12'h020, 16'hBEEF);
    wr(OFS_CCR, 16'h0145);
    wr(OFS_SWTRIG, 16'h0001);
    wait_rdy();
    chk("irq", {15'h0, irq_q}, 16'h0001);
    scan_chk("single word", 16, 16'h8005, 1);
    rdc("word 16", OFS_BUF_LO + 12'h020, 16'hBEEF);
    rdc("status", OFS_CSR, 16'h0020);
    chk("irq", {15'h0, irq_q}, 16'h0000);
    // block of eight, timer trigger, don't-care group bits set
    // data ready at the middle word as well, then at the end
    wr(OFS_CSR, 16'h2400);
    wr(OFS_CCR, 16'h087B);
    @(posedge ref_clk);
    timer_trig <= 1'b1;
    @(posedge ref_clk);
    timer_trig <= 1'b0;
    wait_rdy();
    rdc("mid status", OFS_CSR, 16'h2450);
    rdc("mid word 7", OFS_BUF_LO + 12'h00E, 16'h001F);
    wait_rdy();
    scan_chk("block word", 16, 16'h0018, 8);
    // random access, external trigger, counter interrupt
    wr(OFS_CSR, 16'h1000);
    wr(OFS_DCOUNT, 16'h0001);
    wr(OFS_CCR, 16'h0589);
    @(posedge ref_clk);
    ext_trig <= 1'b1;
    @(posedge ref_clk);
    ext_trig <= 1'b0;
    wait_rdy();
    chk("irq", {15'h0, irq_q}, 16'h0001);
    // a disabled request stays low while its source is set
    @(posedge ref_clk);
    irq_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("irq masked", {15'h0, irq_q}, 16'h0000);
    @(posedge ref_clk);
    irq_enable <= 1'b1;
    rdc("random word 0", OFS_BUF_LO, 16'h8009);
    rdc("random word 1", OFS_BUF_LO + 12'h002, 16'h0019);
    // auto scan with per-channel gain re-arms by itself
    wr(OFS_CSR, 16'h0000);
    wr(OFS_GAIN, 16'h0042);
    wr(OFS_CCR, 16'h0202);
    wr(OFS_SWTRIG, 16'h0001);
    wait_rdy();
    rdc("auto word 0", OFS_BUF_LO, 16'h8002);
    wait_rdy();
    wr(OFS_CCR, 16'h0040);
    rdc("clear", OFS_BUF_LO, 16'h0000, 1'b0);
    // reserved trigger mode never fires
    wr(OFS_CSR, 16'h3000);
    wr(OFS_SWTRIG, 16'h0001);
    @(posedge ref_clk);
    {ext_trig, timer_trig} <= 2'b11;
    @(posedge ref_clk);
    {ext_trig, timer_trig} <= 2'b00;
    repeat (4) @(posedge ref_clk);
    rdc("status", OFS_CSR, 16'h3020);
    wr(OFS_SWRESET, 16'h0001);
    rdc("config", OFS_CCR, 16'h0000);
    rdc("status", OFS_CSR, 16'h0020);
    // unasked results fill the fifo until it refuses
    @(posedge ref_clk);
    flood <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk("fifo ready", {15'h0, conv_ready_q}, 16'h0000);
    print_verdict();
  end
endmodule // tb_adsc_scan_config

bind adsc_scan_config adsc_scan_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
  .irq_enable(irq_enable), .irq_q(irq_q), .conv_req_q(conv_req_q), .conv_chan_q(conv_chan_q),
  .conv_gain_x10_q(conv_gain_x10_q));

`default_nettype wire
